// File: include/upc_pkg.sv
// Purpose: shared constants and carrier types for the uplink power control loop
// Assumes: 20 MHz clock, APB register access with 32-bit data
// Notes: power, target and signal-to-noise figures are held in 0.1 dB units
package upc_pkg;
    // register byte offsets
    localparam logic [7:0] UPC_OFS_CTRL = 8'h00;
    localparam logic [7:0] UPC_OFS_TARGET = 8'h04;
    localparam logic [7:0] UPC_OFS_RANGE = 8'h08;
    localparam logic [7:0] UPC_OFS_NOMINAL = 8'h0C;
    localparam logic [7:0] UPC_OFS_MONITOR = 8'h10;
    localparam logic [7:0] UPC_OFS_INT_STAT = 8'h14;
    localparam logic [7:0] UPC_OFS_INT_MASK = 8'h18;
    // control field positions
    localparam int UPC_CTRL_AUTO = 0;
    localparam int UPC_CTRL_ALARM = 1;
    localparam int UPC_CTRL_UNLOCK_MAX = 2;
    localparam int UPC_CTRL_FRAME_LSB = 4;
    localparam int UPC_FRAME_W = 3;
    // monitor field positions
    localparam int UPC_MON_OFFSET_LSB = 8;
    localparam int UPC_MON_ATMAX = 16;
    // framing codes
    localparam logic [2:0] UPC_FRAME_NONE = 3'h0;
    localparam logic [2:0] UPC_FRAME_EMBEDDED_MGMT = 3'h1;
    localparam logic [2:0] UPC_FRAME_DROP_INSERT_EXT = 3'h2;
    localparam logic [2:0] UPC_FRAME_EXT_SERVICE = 3'h3;
    // limits and reset values, 0.1 dB units except range, which is in whole dB
    localparam logic [6:0] UPC_TARGET_MAX = 7'h63;
    localparam logic [6:0] UPC_TARGET_RST = 7'h1E;
    localparam logic [3:0] UPC_RANGE_MAX = 4'h9;
    localparam logic [3:0] UPC_RANGE_RST = 4'h1;
    localparam logic [6:0] UPC_DB_TO_TENTHS = 7'h0A;
    localparam logic [7:0] UPC_NOMINAL_RST = 8'h00;
    localparam logic [7:0] UPC_SNR_CLIP = 8'hA0;
    localparam logic [9:0] UPC_FINE_BAND = 10'h005;
    localparam logic [13:0] UPC_DAMP_NUM = 14'h0008;
    localparam logic [13:0] UPC_DAMP_DEN = 14'h000A;
    // interrupt bits
    localparam int UPC_IRQ_W = 4;
    localparam int UPC_EV_CORR = 0;
    localparam int UPC_EV_ATMAX = 1;
    localparam int UPC_EV_REMOTE_UNLOCK = 2;
    localparam int UPC_EV_LOCAL_UNLOCK = 3;
    // correction pacing
    localparam int unsigned UPC_PACE_S = 4;
    localparam int unsigned UPC_CLK_HZ = 20000000;
    localparam int unsigned UPC_PACE_CYCLES = UPC_PACE_S * UPC_CLK_HZ;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } upc_apb_req_t;

    typedef struct packed {
        logic auto_en;
        logic alarm_act;
        logic unlock_max;
        logic [2:0] framing;
    } upc_ctrl_t;

    typedef struct packed {
        upc_ctrl_t ctrl;
        logic [6:0] target;
        logic [3:0] range;
        logic [7:0] nominal;
        logic [6:0] offset;
        logic damp_done;
        logic [31:0] pace;
        logic [7:0] snr;
        logic remote_lock;
        logic local_lock;
        logic atmax;
        logic [3:0] int_stat;
        logic [3:0] int_mask;
        logic ack;
        logic [31:0] prdata;
        logic [7:0] tx_power;
        logic tx_alarm;
    } upc_state_t;
endpackage

// File: hw/upc_top.sv
// Purpose: closed-loop uplink transmit power control with APB registers
// Assumes: remote signal-to-noise figure arrives as a strobe with 0.1 dB data
// Notes: power offset above nominal is held in 0.1 dB units, 0 to range*10
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps

// Notes on behaviour
// - automatic control only with embedded management, drop-insert extended or service framing
// - nominal power is the manual level set before auto mode; lower bound
// - target accepts 0.0 to 9.9 dB in 0.1 dB, reset 3.0 dB
// - remote figure above target lowers power, never below nominal
// - remote figure below target raises power, never above nominal plus range
// - range accepts 0 to 9 whole dB, reset 1 dB
// - alarm setting off by default, else transmit alarm at power ceiling
// - remote demod unlock moves power to nominal or ceiling as configured
// - local demod unlock forces nominal power unconditionally
// - corrections applied at most once every 4 seconds
// - first correction of a change is 80 percent of the step
// - corrections continue until error under 0.5 dB, then 0.1 dB steps
// - reported remote figure has 0.2 dB resolution, clipped at 16.0 dB
// - remote figure readable whenever framing on, regardless of auto mode
// - reported power increase reads 0.0 dB when auto control is off
module upc_top #(
    parameter int unsigned PACE_CYCLES = upc_pkg::UPC_PACE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire upc_pkg::upc_apb_req_t apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic snr_valid_in,
    input wire logic [7:0] snr_in,
    input wire logic remote_lock_in,
    input wire logic local_lock_in,
    output logic [7:0] tx_power_out,
    output logic tx_alarm_out,
    output logic irq_out
);
    import upc_pkg::*;

    logic [1:0] rst_q;
    logic rst_n;
    upc_state_t st;
    upc_state_t next_st;
    logic framed;
    logic auto_ok;
    logic [6:0] ceiling;
    logic signed [9:0] err;
    logic signed [9:0] step;
    logic signed [13:0] damp_prod;
    logic signed [10:0] sum;
    logic [6:0] sat;
    logic corr;
    logic [7:0] snr_rep;
    logic [6:0] off_rep;
    logic mapped;
    logic access;
    logic [3:0] events;
    logic [31:0] rd;

    // reset release through two flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // framing and mode qualification
    assign framed = st.ctrl.framing != UPC_FRAME_NONE;
    assign auto_ok = st.ctrl.auto_en && (st.ctrl.framing == UPC_FRAME_EMBEDDED_MGMT
        || st.ctrl.framing == UPC_FRAME_DROP_INSERT_EXT
        || st.ctrl.framing == UPC_FRAME_EXT_SERVICE);
    assign ceiling = 7'(st.range * UPC_DB_TO_TENTHS);

    // error and paced step size
    assign err = $signed({3'h0, st.target}) - $signed({2'h0, st.snr});
    assign damp_prod = (14'(err) * $signed(UPC_DAMP_NUM)) / $signed(UPC_DAMP_DEN);
    always_comb begin
        step = 10'sh000;
        if (err >= $signed(UPC_FINE_BAND) || err <= -$signed(UPC_FINE_BAND)) begin
            step = st.damp_done ? err : 10'(damp_prod);
        end else if (err > 10'sh000) begin
            step = 10'sh001;
        end else if (err < 10'sh000) begin
            step = -10'sh001;
        end
    end

    // saturate new offset between nominal and ceiling
    assign sum = $signed({4'h0, st.offset}) + 11'(step);
    always_comb begin
        if (sum < 11'sh000) begin
            sat = 7'h00;
        end else if (sum > $signed({4'h0, ceiling})) begin
            sat = ceiling;
        end else begin
            sat = sum[6:0];
        end
    end
    assign corr = auto_ok && st.local_lock && st.remote_lock
        && st.pace == 32'(PACE_CYCLES - 1);

    // monitored values
    assign snr_rep = !framed ? 8'h00 : (st.snr >= UPC_SNR_CLIP) ? UPC_SNR_CLIP
        : {st.snr[7:1], 1'b0};
    assign off_rep = auto_ok ? st.offset : 7'h00;

    // bus decode
    assign access = apb_in.psel && apb_in.penable && st.ack;
    assign mapped = apb_in.paddr == UPC_OFS_CTRL || apb_in.paddr == UPC_OFS_TARGET
        || apb_in.paddr == UPC_OFS_RANGE || apb_in.paddr == UPC_OFS_NOMINAL
        || apb_in.paddr == UPC_OFS_MONITOR || apb_in.paddr == UPC_OFS_INT_STAT
        || apb_in.paddr == UPC_OFS_INT_MASK;

    // read mux
    always_comb begin
        rd = 32'h0000_0000;
        unique case (apb_in.paddr)
            UPC_OFS_CTRL: begin
                rd[UPC_CTRL_AUTO] = st.ctrl.auto_en;
                rd[UPC_CTRL_ALARM] = st.ctrl.alarm_act;
                rd[UPC_CTRL_UNLOCK_MAX] = st.ctrl.unlock_max;
                rd[UPC_CTRL_FRAME_LSB +: UPC_FRAME_W] = st.ctrl.framing;
            end
            UPC_OFS_TARGET: rd[6:0] = st.target;
            UPC_OFS_RANGE: rd[3:0] = st.range;
            UPC_OFS_NOMINAL: rd[7:0] = st.nominal;
            UPC_OFS_MONITOR: begin
                rd[7:0] = snr_rep;
                rd[UPC_MON_OFFSET_LSB +: 7] = off_rep;
                rd[UPC_MON_ATMAX] = st.atmax;
            end
            UPC_OFS_INT_STAT: rd[3:0] = st.int_stat;
            UPC_OFS_INT_MASK: rd[3:0] = st.int_mask;
            default: rd = 32'h0000_0000;
        endcase
    end

    // next state of the whole block
    always_comb begin
        next_st = st;
        events = 4'h0;
        next_st.remote_lock = remote_lock_in;
        next_st.local_lock = local_lock_in;
        if (snr_valid_in) begin
            next_st.snr = snr_in;
        end
        // apb: one wait state, prdata registered
        next_st.ack = apb_in.psel && apb_in.penable && !st.ack;
        if (next_st.ack && !apb_in.pwrite) begin
            next_st.prdata = rd;
        end
        // pacing timer
        next_st.pace = (st.pace >= 32'(PACE_CYCLES - 1)) ? 32'h0 : st.pace + 32'h1;
        // control loop
        if (!auto_ok || !st.local_lock) begin
            next_st.offset = 7'h00;
            next_st.damp_done = 1'b0;
        end else if (!st.remote_lock) begin
            next_st.offset = st.ctrl.unlock_max ? ceiling : 7'h00;
            next_st.damp_done = 1'b0;
        end else if (corr) begin
            next_st.offset = sat;
            next_st.damp_done = (err >= $signed(UPC_FINE_BAND)
                || err <= -$signed(UPC_FINE_BAND));
            events[UPC_EV_CORR] = step != 10'sh000;
        end else if (st.offset > ceiling) begin
            next_st.offset = ceiling;
        end
        next_st.atmax = auto_ok && next_st.offset == ceiling;
        events[UPC_EV_ATMAX] = next_st.atmax && !st.atmax;
        events[UPC_EV_REMOTE_UNLOCK] = st.remote_lock && !remote_lock_in;
        events[UPC_EV_LOCAL_UNLOCK] = st.local_lock && !local_lock_in;
        // register writes take effect at the edge that completes access
        if (access && apb_in.pwrite) begin
            unique case (apb_in.paddr)
                UPC_OFS_CTRL: begin
                    next_st.ctrl.auto_en = apb_in.pwdata[UPC_CTRL_AUTO];
                    next_st.ctrl.alarm_act = apb_in.pwdata[UPC_CTRL_ALARM];
                    next_st.ctrl.unlock_max = apb_in.pwdata[UPC_CTRL_UNLOCK_MAX];
                    next_st.ctrl.framing = apb_in.pwdata[UPC_CTRL_FRAME_LSB +: UPC_FRAME_W];
                end
                UPC_OFS_TARGET: begin
                    if (apb_in.pwdata[6:0] <= UPC_TARGET_MAX && apb_in.pwdata[31:7] == 25'h0) begin
                        next_st.target = apb_in.pwdata[6:0];
                    end
                end
                UPC_OFS_RANGE: begin
                    if (apb_in.pwdata[3:0] <= UPC_RANGE_MAX && apb_in.pwdata[31:4] == 28'h0) begin
                        next_st.range = apb_in.pwdata[3:0];
                    end
                end
                UPC_OFS_NOMINAL: begin
                    if (!auto_ok) begin
                        next_st.nominal = apb_in.pwdata[7:0];
                    end
                end
                UPC_OFS_INT_MASK: next_st.int_mask = apb_in.pwdata[3:0];
                UPC_OFS_INT_STAT: next_st.int_stat = st.int_stat & ~apb_in.pwdata[3:0];
                default: next_st.int_stat = next_st.int_stat;
            endcase
        end
        // set wins over a simultaneous write-one clear
        next_st.int_stat = next_st.int_stat | events;
        next_st.tx_power = st.nominal + {1'b0, next_st.offset};
        next_st.tx_alarm = st.ctrl.alarm_act && next_st.atmax;
    end

    // single state register, frozen while clock enable is low
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.target <= UPC_TARGET_RST;
            st.range <= UPC_RANGE_RST;
            st.nominal <= UPC_NOMINAL_RST;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign prdata_out = st.prdata;
    assign pready_out = st.ack;
    assign pslverr_out = st.ack && !mapped;
    assign tx_power_out = st.tx_power;
    assign tx_alarm_out = st.tx_alarm;
    assign irq_out = |(st.int_stat & st.int_mask);

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_apb_setup;
        apb_in.psel && !apb_in.penable && ce_in;
    endsequence
    sequence s_apb_answer;
        apb_in.psel && apb_in.penable && !st.ack && ce_in ##1 st.ack;
    endsequence

    a_apb_one_wait: assert property (s_apb_setup ##1 (apb_in.psel && apb_in.penable && ce_in)
        |=> st.ack)
        else $error("apb answer not after one wait state");
    a_apb_ready_clear: assert property (s_apb_answer ##0 ce_in |=> !st.ack)
        else $error("pready held beyond one cycle");
    a_frame_gate_off: assert property (ce_in && !auto_ok |=> st.offset == 7'h00)
        else $error("offset nonzero without qualified framing");
    a_nominal_held: assert property (auto_ok |=> $stable(st.nominal))
        else $error("nominal changed under auto control");
    a_target_limit: assert property (st.target <= UPC_TARGET_MAX)
        else $error("target out of range");
    a_offset_bounds: assert property (st.offset <= ceiling || $changed(st.range))
        else $error("offset above ceiling");
    a_range_limit: assert property (st.range <= UPC_RANGE_MAX)
        else $error("range out of range");
    a_alarm_ceiling: assert property (ce_in |=> tx_alarm_out
        == (st.ctrl.alarm_act && $past(st.ctrl.alarm_act) && st.atmax) || $changed(st.ctrl))
        else $error("alarm does not track ceiling");
    a_remote_unlock: assert property (ce_in && auto_ok && st.local_lock && !st.remote_lock
        |=> st.offset == ($past(st.ctrl.unlock_max) ? $past(ceiling) : 7'h00))
        else $error("remote unlock action wrong");
    a_local_unlock: assert property (ce_in && !st.local_lock |=> st.offset == 7'h00)
        else $error("local unlock did not force nominal");
    a_pace_spacing: assert property (ce_in && corr |=> !corr)
        else $error("corrections closer than pacing interval");
    a_fine_step: assert property (ce_in && corr && st.damp_done && err < $signed(UPC_FINE_BAND)
        && err > -$signed(UPC_FINE_BAND) && err != 10'sh000 && sat != 7'h00 && sat != ceiling
        |=> st.offset == $past(st.offset) + 7'h01 || st.offset == $past(st.offset) - 7'h01)
        else $error("fine correction not one tenth dB");
    a_snr_report: assert property (snr_rep <= UPC_SNR_CLIP && !snr_rep[0])
        else $error("reported figure not quantised or clipped");
    a_power_report: assert property (!auto_ok |-> off_rep == 7'h00)
        else $error("power increase nonzero without auto control");

    // bus answer only after an access phase, error only with ready
    a_ack_after_access: assert property (ce_in && !(apb_in.psel && apb_in.penable)
        |=> !st.ack)
        else $error("pready without an access phase");
    a_slverr_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr outside the answer cycle");
    a_unmapped_reads_zero: assert property (st.ack && !mapped && !apb_in.pwrite
        |-> prdata_out == 32'h0000_0000)
        else $error("unmapped read returned data");

    // out-of-range writes leave the setting alone
    a_target_refused: assert property (ce_in && access && apb_in.pwrite
        && apb_in.paddr == UPC_OFS_TARGET && apb_in.pwdata[6:0] > UPC_TARGET_MAX
        |=> $stable(st.target))
        else $error("target took an illegal value");
    a_range_refused: assert property (ce_in && access && apb_in.pwrite
        && apb_in.paddr == UPC_OFS_RANGE && apb_in.pwdata[3:0] > UPC_RANGE_MAX
        |=> $stable(st.range))
        else $error("range took an illegal value");
    a_nominal_write: assert property (ce_in && !auto_ok && access && apb_in.pwrite
        && apb_in.paddr == UPC_OFS_NOMINAL |=> st.nominal == $past(apb_in.pwdata[7:0]))
        else $error("manual nominal write lost");
    a_mask_write: assert property (ce_in && access && apb_in.pwrite
        && apb_in.paddr == UPC_OFS_INT_MASK |=> st.int_mask == $past(apb_in.pwdata[3:0]))
        else $error("mask write lost");

    // enable low freezes the block, power is nominal plus offset
    a_ce_freeze: assert property (!ce_in |=> $stable(st))
        else $error("state moved while clock enable low");
    a_power_sum: assert property (ce_in |=> st.tx_power
        == $past(st.nominal) + {1'b0, st.offset})
        else $error("transmit power not nominal plus offset");

    // direction of a correction follows the sign of the error
    sequence s_corr_up;
        ce_in && corr && err > 10'sh000;
    endsequence
    sequence s_corr_down;
        ce_in && corr && err < 10'sh000;
    endsequence
    a_lower_only: assert property (s_corr_down |=> st.offset <= $past(st.offset))
        else $error("power raised with figure above target");
    a_raise_only: assert property (s_corr_up ##0 st.offset <= ceiling
        |=> st.offset >= $past(st.offset))
        else $error("power lowered with figure below target");
    a_hold_between: assert property (ce_in && auto_ok && st.local_lock && st.remote_lock
        && !corr && st.offset <= ceiling |=> $stable(st.offset))
        else $error("power moved between corrections");
    a_pace_wrap: assert property (ce_in && st.pace == 32'(PACE_CYCLES - 1)
        |=> st.pace == 32'h0)
        else $error("pacing counter did not wrap");

    // damping applies to the first large step only
    a_damp_first: assert property (ce_in && corr && !st.damp_done && (err >= $signed(UPC_FINE_BAND)
        || err <= -$signed(UPC_FINE_BAND)) |=> st.damp_done)
        else $error("damped step not recorded");
    a_damp_fine: assert property (ce_in && corr && err < $signed(UPC_FINE_BAND)
        && err > -$signed(UPC_FINE_BAND) |=> !st.damp_done)
        else $error("damping not rearmed in fine band");

    // alarm and ceiling flag need their settings
    a_alarm_off: assert property (ce_in && !st.ctrl.alarm_act |=> !tx_alarm_out)
        else $error("alarm without alarm action");
    a_atmax_auto: assert property (ce_in && !auto_ok |=> !st.atmax)
        else $error("ceiling flag without auto control");

    // monitored figure blank without framing, captured on each strobe
    a_snr_unframed: assert property (!framed |-> snr_rep == 8'h00)
        else $error("figure reported without framing");
    a_snr_capture: assert property (ce_in && snr_valid_in |=> st.snr == $past(snr_in))
        else $error("remote figure not captured");

    // sticky status bits, set wins, level interrupt
    a_corr_event: assert property (ce_in && corr && step != 10'sh000
        |=> st.int_stat[UPC_EV_CORR])
        else $error("correction event lost");
    a_local_event: assert property (ce_in && st.local_lock && !local_lock_in
        |=> st.int_stat[UPC_EV_LOCAL_UNLOCK])
        else $error("local unlock event lost");
    a_remote_event: assert property (ce_in && st.remote_lock && !remote_lock_in
        |=> st.int_stat[UPC_EV_REMOTE_UNLOCK])
        else $error("remote unlock event lost");
    a_stat_sticky: assert property (ce_in && st.int_stat[UPC_EV_CORR]
        && !(access && apb_in.pwrite && apb_in.paddr == UPC_OFS_INT_STAT)
        |=> st.int_stat[UPC_EV_CORR])
        else $error("status bit cleared without a write");
    a_irq_masked: assert property (st.int_mask == 4'h0 |-> !irq_out)
        else $error("interrupt with all sources masked");
endmodule

// File: dv/upc_remote_model.sv
// Purpose: behavioural far-end modem returning its demodulator figure
// Assumes: the far-end figure rises one for one with our power above nominal
// Notes: path quality and demodulator lock are commanded by the bench
`timescale 1ns/10ps
module upc_remote_model (
    input wire logic clk_in,
    input wire logic [7:0] tx_power_in,
    input wire logic [7:0] nominal_in,
    input wire logic [7:0] path_snr_in,
    input wire logic lock_cmd_in,
    output logic snr_valid_out,
    output logic [7:0] snr_out,
    output logic remote_lock_out
);
    logic [8:0] sum;
    // received figure: path quality plus our power increase, clipped to a byte
    always_comb begin
        sum = {1'b0, path_snr_in};
        if (tx_power_in > nominal_in) begin
            sum = sum + {1'b0, tx_power_in - nominal_in};
        end
    end
    // figure sent back every other clock cycle, line toggles between
    initial begin
        snr_valid_out = 1'b0;
        snr_out = 8'h00;
    end
    always @(posedge clk_in) begin
        snr_valid_out <= !snr_valid_out;
        snr_out <= snr_valid_out ? ~sum[7:0] : (sum[8] ? 8'hFF : sum[7:0]);
    end
    assign remote_lock_out = lock_cmd_in;
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the uplink power control loop
// Assumes: short correction pacing, far-end modem model in closed loop
// Notes: register access through apb tasks, power watched at tx_power_out
`timescale 1ns/10ps
module testbench;
    import upc_pkg::*;
    localparam int PACE = 20;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    upc_apb_req_t apb = '0;
    logic [31:0] prdata;
    logic pready, pslverr, snr_valid, remote_lock, tx_alarm, irq;
    logic [7:0] snr, tx_power;
    logic local_lock = 1'b1;
    logic remote_cmd = 1'b1;
    logic [7:0] nominal = 8'h32;
    logic [7:0] path_snr = 8'h00;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int t_hit, t0;
    logic [7:0] ta [7] = '{UPC_OFS_TARGET, UPC_OFS_TARGET, UPC_OFS_RANGE, UPC_OFS_RANGE,
        UPC_OFS_RANGE, UPC_OFS_TARGET, UPC_OFS_NOMINAL};
    logic [31:0] td [7] = '{32'h64, 32'h63, 32'hA, 32'h0, 32'h9, 32'h1E, 32'h32};
    logic [31:0] te [7] = '{32'h1E, 32'h63, 32'h1, 32'h0, 32'h9, 32'h1E, 32'h32};

    upc_top #(.PACE_CYCLES(PACE)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .apb_in(apb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .snr_valid_in(snr_valid), .snr_in(snr), .remote_lock_in(remote_lock),
        .local_lock_in(local_lock), .tx_power_out(tx_power), .tx_alarm_out(tx_alarm),
        .irq_out(irq));
    upc_remote_model u_far (.clk_in(clk_in), .tx_power_in(tx_power), .nominal_in(nominal),
        .path_snr_in(path_snr), .lock_cmd_in(remote_cmd), .snr_valid_out(snr_valid),
        .snr_out(snr), .remote_lock_out(remote_lock));

    // clock and hang guard
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_in);
        apb.penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk_in);
        end
        rd = prdata;
        err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask
    // wait a bounded time for a power level, then compare
    task automatic wait_tx(input string what, input logic [7:0] exp);
        int n;
        n = 0;
        while (tx_power !== exp && n < 3 * PACE) begin
            @(posedge clk_in);
            n++;
        end
        t_hit = cyc;
        check(what, tx_power, exp);
    endtask
    // let a lock or register change reach the outputs before looking at them
    task automatic settle();
        repeat (3) @(posedge clk_in);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rdchk("ctrl", UPC_OFS_CTRL, 32'h0);
        xfer(1'b0, 8'h1C, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, ta[i], td[i]);
            rdchk("readback", ta[i], te[i]);
        end
        $display("test registers done");
        xfer(1'b1, UPC_OFS_CTRL, 32'h10);
        path_snr <= 8'hC8;
        repeat (4) @(posedge clk_in);
        rdchk("monitor clip", UPC_OFS_MONITOR, 32'hA0);
        path_snr <= 8'h26;
        repeat (4) @(posedge clk_in);
        rdchk("monitor auto off", UPC_OFS_MONITOR, 32'h26);
        check("nominal power", tx_power, 8'h32);
        path_snr <= 8'h00;
        for (int c = 0; c < 2; c++) begin
            xfer(1'b1, UPC_OFS_CTRL, c == 0 ? 32'h01 : 32'h41);
            repeat (3 * PACE) @(posedge clk_in);
            check("framing refusal", tx_power, 8'h32);
        end
        $display("test monitor done");
        xfer(1'b1, UPC_OFS_INT_MASK, 32'h8);
        for (int f = 1; f <= 3; f++) begin
            xfer(1'b1, UPC_OFS_CTRL, {25'h0, 3'(f), 4'h1});
            wait_tx("damped step", 8'h4A);
            t0 = t_hit;
            wait_tx("full step", 8'h50);
            check("pacing", 32'(t_hit - t0), 32'(PACE));
            local_lock <= 1'b0;
            settle();
            check("local unlock", tx_power, 8'h32);
            check("irq raised", irq, 1'b1);
            xfer(1'b1, UPC_OFS_INT_MASK, 32'h0);
            settle();
            check("irq masked", irq, 1'b0);
            xfer(1'b1, UPC_OFS_INT_MASK, 32'h8);
            xfer(1'b1, UPC_OFS_CTRL, {25'h0, 3'(f), 4'h0});
            local_lock <= 1'b1;
            xfer(1'b1, UPC_OFS_INT_STAT, 32'h8);
            settle();
            check("irq cleared", irq, 1'b0);
        end
        $display("test loop done");
        path_snr <= 8'h1B;
        xfer(1'b1, UPC_OFS_CTRL, 32'h11);
        wait_tx("fine step 1", 8'h33);
        wait_tx("fine step 2", 8'h34);
        wait_tx("fine step 3", 8'h35);
        path_snr <= 8'h28;
        wait_tx("floor", 8'h32);
        repeat (PACE + 2) @(posedge clk_in);
        check("floor held", tx_power, 8'h32);
        $display("test fine done");
        path_snr <= 8'h00;
        xfer(1'b1, UPC_OFS_RANGE, 32'h1);
        xfer(1'b1, UPC_OFS_TARGET, 32'h63);
        wait_tx("ceiling", 8'h3C);
        check("alarm off", tx_alarm, 1'b0);
        xfer(1'b1, UPC_OFS_CTRL, 32'h13);
        settle();
        check("alarm on", tx_alarm, 1'b1);
        rdchk("monitor ceiling", UPC_OFS_MONITOR, 32'h10A0A);
        remote_cmd <= 1'b0;
        settle();
        check("remote unlock nominal", tx_power, 8'h32);
        remote_cmd <= 1'b1;
        xfer(1'b1, UPC_OFS_CTRL, 32'h17);
        remote_cmd <= 1'b0;
        settle();
        check("remote unlock ceiling", tx_power, 8'h3C);
        $display("test ceiling done");
        final_report();
    end
endmodule
